// ==== hdl/ability_pkg.sv ====
// constants for the auto-negotiation ability register bank
package ability_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h000;
  localparam logic [9:0] IDX_STATUS = 10'h001;
  localparam logic [9:0] IDX_ADV = 10'h004;
  localparam logic [9:0] IDX_PARTNER = 10'h005;
  localparam logic [9:0] IDX_EXPANSION = 10'h006;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h010;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h011;
  // advertisement fields
  localparam int ADV_RFAULT = 13;
  localparam int ADV_PAUSE_SYM = 10;
  localparam int ADV_PAUSE_ASYM = 11;
  localparam int ADV_100FD = 8;
  localparam int ADV_100TX = 7;
  localparam int ADV_10FD = 6;
  localparam int ADV_10HD = 5;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam logic [15:0] ADV_WR_MASK = 16'h2dff;
  // partner ability fields
  localparam int LP_NP = 15;
  localparam int LP_ACK = 14;
  localparam int LP_RFAULT = 13;
  localparam int LP_PAUSE = 10;
  localparam int LP_T4 = 9;
  localparam logic [15:0] LP_CAPTURE_MASK = 16'h25ff;
  // expansion fields
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP = 3;
  localparam int EXP_NP_ABLE = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_AN = 0;
  // control and status fields
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int STAT_COMPLETE = 5;
  localparam int STAT_AN_ABLE = 3;
  localparam logic CTRL_AN_EN_RST = 1'b1;
  localparam logic CTRL_SPEED_RST = 1'b1;
  localparam logic CTRL_DUPLEX_RST = 1'b0;
  // interrupt status and mask bits
  localparam int IRQ_PAGE_RX = 0;
  localparam int IRQ_PD_FAULT = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_WIDTH = 3;
  localparam int LATCH_WIDTH = 2;
  typedef enum logic [1:0] {
    PAUSE_NONE = 2'b00,
    PAUSE_SYM = 2'b01,
    PAUSE_ASYM = 2'b10
  } pause_t;
endpackage

// ==== hdl/ability_if.sv ====
// ability words and resolved link settings between bank and resolver
`timescale 1ns/1ps
interface ability_if;
  logic [15:0] local_adv;
  logic [15:0] partner;
  logic an_enable;
  logic manual_speed;
  logic manual_duplex;
  logic complete;
  logic speed_100;
  logic full_duplex;
  ability_pkg::pause_t pause_mode;
  modport bank (
    output local_adv, partner, an_enable, manual_speed, manual_duplex, complete,
    input speed_100, full_duplex, pause_mode
  );
  modport resolver (
    input local_adv, partner, an_enable, manual_speed, manual_duplex, complete,
    output speed_100, full_duplex, pause_mode
  );
endinterface

// ==== hdl/latched_flags.sv ====
// latched-high flags: set by event, cleared by read, set wins
`timescale 1ns/1ps
module latched_flags #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      // an event in the clearing cycle survives
      assign flags_d[i] = set[i] | (flags_q[i] & ~clear[i]);
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (srst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;
endmodule

// ==== hdl/link_resolver.sv ====
// resolves speed, duplex and pause from the two ability words
`timescale 1ns/1ps
module link_resolver (
  input wire logic clock,
  input wire logic srst,
  ability_if.resolver ab
);
  logic [3:0] common;
  logic lsym;
  logic lasym;
  logic psym;
  logic pasym;
  logic speed_d;
  logic duplex_d;
  logic take;
  ability_pkg::pause_t pause_d;
  logic speed_q;
  logic duplex_q;
  ability_pkg::pause_t pause_q;

  assign common = ab.local_adv[ability_pkg::ADV_100FD:ability_pkg::ADV_10HD]
    & ab.partner[ability_pkg::ADV_100FD:ability_pkg::ADV_10HD];
  assign lsym = ab.local_adv[ability_pkg::ADV_PAUSE_SYM];
  assign lasym = ab.local_adv[ability_pkg::ADV_PAUSE_ASYM];
  assign psym = ab.partner[ability_pkg::LP_PAUSE];
  // partner asymmetric bit is not kept in the bank, taken as clear
  assign pasym = 1'b0;
  // highest common ability wins
  assign speed_d = ab.an_enable ? (common[3] | common[2]) : ab.manual_speed;
  assign duplex_d = ab.an_enable ? (common[3] | (~common[2] & common[1])) : ab.manual_duplex;
  // only one of the two pause settings is ever chosen
  assign pause_d = !ab.an_enable ? ability_pkg::PAUSE_NONE :
    (lsym & psym) ? ability_pkg::PAUSE_SYM :
    (lasym & psym & pasym) ? ability_pkg::PAUSE_ASYM :
    ability_pkg::PAUSE_NONE;
  // negotiated values move only after completion
  assign take = ~ab.an_enable | ab.complete;

  always_ff @(posedge clock) begin
    if (srst) begin
      speed_q <= 1'b0;
      duplex_q <= 1'b0;
      pause_q <= ability_pkg::PAUSE_NONE;
    end else if (take) begin
      speed_q <= speed_d;
      duplex_q <= duplex_d;
      pause_q <= pause_d;
    end
  end

  assign ab.speed_100 = speed_q;
  assign ab.full_duplex = duplex_q;
  assign ab.pause_mode = pause_q;
endmodule

// ==== hdl/autoneg_ability_registers.sv ====
// auto-negotiation ability register bank behind an APB slave
`timescale 1ns/1ps
module autoneg_ability_registers (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strap_100fd,
  input wire logic strap_10fd,
  input wire logic strap_10hd,
  input wire logic code_word_valid,
  input wire logic [15:0] code_word,
  input wire logic parallel_fault,
  input wire logic negotiation_done,
  output logic speed_100,
  output logic full_duplex,
  output logic [1:0] pause_mode,
  output logic irq
);
  ability_if ab ();

  // register index from a byte address; misaligned never matches
  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = (addr[1:0] == 2'b00) ? addr[11:2] : 10'h3ff;
  endfunction

  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (reg_index(addr) == idx);
  endfunction

  localparam int IRQ_W = ability_pkg::IRQ_WIDTH;
  logic [15:0] adv_q;
  logic [15:0] adv_d;
  logic [15:0] partner_q;
  logic [15:0] partner_d;
  logic an_en_q;
  logic speed_sel_q;
  logic duplex_sel_q;
  logic complete_q;
  logic complete_d;
  logic lp_np_q;
  logic lp_an_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_status_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] prdata_q;

  // bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic hit_ctrl;
  logic hit_status;
  logic hit_adv;
  logic hit_partner;
  logic hit_exp;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic mapped;
  logic wr_ctrl;
  logic wr_adv;
  logic wr_irq_st;
  logic wr_irq_mask;
  logic rd_exp;
  logic restart;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite;
  assign rd_acc = access_ph & ~pwrite;
  assign hit_ctrl = hit(paddr, ability_pkg::IDX_CTRL);
  assign hit_status = hit(paddr, ability_pkg::IDX_STATUS);
  assign hit_adv = hit(paddr, ability_pkg::IDX_ADV);
  assign hit_partner = hit(paddr, ability_pkg::IDX_PARTNER);
  assign hit_exp = hit(paddr, ability_pkg::IDX_EXPANSION);
  assign hit_irq_st = hit(paddr, ability_pkg::IDX_IRQ_STATUS);
  assign hit_irq_mask = hit(paddr, ability_pkg::IDX_IRQ_MASK);
  assign mapped = hit_ctrl | hit_status | hit_adv | hit_partner | hit_exp
    | hit_irq_st | hit_irq_mask;
  assign wr_ctrl = wr_acc & hit_ctrl;
  assign wr_adv = wr_acc & hit_adv;
  assign wr_irq_st = wr_acc & hit_irq_st;
  assign wr_irq_mask = wr_acc & hit_irq_mask;
  assign rd_exp = rd_acc & hit_exp;
  // self-clearing restart: acts in the write cycle only
  assign restart = wr_ctrl & pwdata[ability_pkg::CTRL_RESTART];

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_q;

  // advertisement: only documented writable bits move
  assign adv_d = (adv_q & ~ability_pkg::ADV_WR_MASK)
    | (pwdata[15:0] & ability_pkg::ADV_WR_MASK);

  always_ff @(posedge clock) begin
    if (srst) begin
      adv_q <= '0;
      adv_q[ability_pkg::ADV_RFAULT] <= 1'b0;
      adv_q[ability_pkg::ADV_PAUSE_ASYM] <= 1'b0;
      adv_q[ability_pkg::ADV_PAUSE_SYM] <= 1'b0;
      adv_q[ability_pkg::ADV_100FD] <= strap_100fd;
      adv_q[ability_pkg::ADV_100TX] <= 1'b1;
      adv_q[ability_pkg::ADV_10FD] <= strap_10fd;
      adv_q[ability_pkg::ADV_10HD] <= strap_10hd;
      adv_q[4:0] <= ability_pkg::SELECTOR_8023;
    end else if (wr_adv) begin
      adv_q <= adv_d;
    end
  end

  // partner word: captured fields plus acknowledge; np and t4 forced low
  always_comb begin
    partner_d = partner_q;
    if (restart) begin
      partner_d[ability_pkg::LP_ACK] = 1'b0;
    end
    if (code_word_valid) begin
      partner_d = code_word & ability_pkg::LP_CAPTURE_MASK;
      partner_d[ability_pkg::LP_ACK] = 1'b1;
    end
    partner_d[ability_pkg::LP_NP] = 1'b0;
    partner_d[ability_pkg::LP_T4] = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      partner_q <= '0;
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
    end else begin
      partner_q <= partner_d;
      if (code_word_valid) begin
        lp_np_q <= code_word[ability_pkg::LP_NP];
        lp_an_q <= 1'b1;
      end
    end
  end

  // control bits steering the resolver
  always_ff @(posedge clock) begin
    if (srst) begin
      an_en_q <= ability_pkg::CTRL_AN_EN_RST;
      speed_sel_q <= ability_pkg::CTRL_SPEED_RST;
      duplex_sel_q <= ability_pkg::CTRL_DUPLEX_RST;
    end else if (wr_ctrl) begin
      an_en_q <= pwdata[ability_pkg::CTRL_AN_EN];
      speed_sel_q <= pwdata[ability_pkg::CTRL_SPEED];
      duplex_sel_q <= pwdata[ability_pkg::CTRL_DUPLEX];
    end
  end

  // completion holds until restart; a done in the restart cycle wins
  assign complete_d = negotiation_done | (complete_q & ~restart);

  always_ff @(posedge clock) begin
    if (srst) begin
      complete_q <= 1'b0;
    end else begin
      complete_q <= complete_d;
    end
  end

  // latched-high expansion flags, cleared only for bits the read returned
  logic [ability_pkg::LATCH_WIDTH-1:0] latch_set;
  logic [ability_pkg::LATCH_WIDTH-1:0] latch_clr;
  logic [ability_pkg::LATCH_WIDTH-1:0] latch_out;
  logic pd_fault_flag;
  logic page_rx_flag;

  assign latch_set = {parallel_fault, code_word_valid};
  assign latch_clr = rd_exp ? {prdata_q[ability_pkg::EXP_PD_FAULT],
    prdata_q[ability_pkg::EXP_PAGE_RX]} : '0;
  assign pd_fault_flag = latch_out[1];
  assign page_rx_flag = latch_out[0];

  latched_flags #(
    .WIDTH(ability_pkg::LATCH_WIDTH)
  ) u_flags (
    .clock(clock),
    .srst(srst),
    .set(latch_set),
    .clear(latch_clr),
    .flags(latch_out)
  );

  // interrupt sources: write one to clear, new event wins over clear
  logic [IRQ_W-1:0] irq_event;
  logic done_prev_q;

  assign irq_event[ability_pkg::IRQ_PAGE_RX] = code_word_valid;
  assign irq_event[ability_pkg::IRQ_PD_FAULT] = parallel_fault;
  assign irq_event[ability_pkg::IRQ_DONE] = complete_q & ~done_prev_q;
  assign irq_status_d = irq_event
    | (irq_status_q & ~(wr_irq_st ? pwdata[IRQ_W-1:0] : '0));

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
      done_prev_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      done_prev_q <= complete_q;
      if (wr_irq_mask) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // read views
  logic [15:0] ctrl_view;
  logic [15:0] status_view;
  logic [15:0] exp_view;
  logic [31:0] rd_mux;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[ability_pkg::CTRL_SPEED] = speed_sel_q;
    ctrl_view[ability_pkg::CTRL_AN_EN] = an_en_q;
    ctrl_view[ability_pkg::CTRL_DUPLEX] = duplex_sel_q;
  end

  always_comb begin
    status_view = '0;
    status_view[ability_pkg::STAT_COMPLETE] = complete_q;
    status_view[ability_pkg::STAT_AN_ABLE] = 1'b1;
  end

  always_comb begin
    exp_view = '0;
    exp_view[ability_pkg::EXP_PD_FAULT] = pd_fault_flag;
    exp_view[ability_pkg::EXP_LP_NP] = lp_np_q;
    exp_view[ability_pkg::EXP_NP_ABLE] = 1'b0;
    exp_view[ability_pkg::EXP_PAGE_RX] = page_rx_flag;
    exp_view[ability_pkg::EXP_LP_AN] = lp_an_q;
  end

  assign rd_mux = hit_ctrl ? {16'h0000, ctrl_view} :
    hit_status ? {16'h0000, status_view} :
    hit_adv ? {16'h0000, adv_q} :
    hit_partner ? {16'h0000, partner_q} :
    hit_exp ? {16'h0000, exp_view} :
    hit_irq_st ? {29'h0000000, irq_status_q} :
    hit_irq_mask ? {29'h0000000, irq_mask_q} :
    32'h00000000;

  // read data is sampled in the setup cycle so it comes from a flop
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata_q <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // resolution of the link settings
  assign ab.local_adv = adv_q;
  assign ab.partner = partner_q;
  assign ab.an_enable = an_en_q;
  assign ab.manual_speed = speed_sel_q;
  assign ab.manual_duplex = duplex_sel_q;
  assign ab.complete = complete_q;

  link_resolver u_resolver (
    .clock(clock),
    .srst(srst),
    .ab(ab)
  );

  assign speed_100 = ab.speed_100;
  assign full_duplex = ab.full_duplex;
  assign pause_mode = ab.pause_mode;
endmodule

// ==== verif/ability_properties.sv ====
// port-level assertions for the ability register bank
`timescale 1ns/1ps
module ability_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic strap_100fd,
  input wire logic strap_10fd,
  input wire logic strap_10hd,
  input wire logic code_word_valid,
  input wire logic [15:0] code_word,
  input wire logic parallel_fault,
  input wire logic negotiation_done,
  input wire logic [1:0] pause_mode
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);
  wire logic acc = psel && penable && pready;
  wire logic rd = acc && !pwrite;
  wire logic wr_adv = acc && pwrite && paddr == 12'h010;
  wire logic rd_adv = rd && paddr == 12'h010;
  wire logic rd_lp = rd && paddr == 12'h014;
  wire logic rd_exp = rd && paddr == 12'h018;
  wire logic rd_st = rd && paddr == 12'h004;
  wire logic ev = parallel_fault || code_word_valid;
  property p_adv_rw;
    wr_adv ##2 rd_adv |-> prdata[15:0] == ($past(pwdata[15:0], 2) & 16'h2dff);
  endproperty
  a_adv_rw: assert property (p_adv_rw) else $error("adv readback");
  property p_strap;
    $fell(srst) ##2 rd_adv |-> prdata[8:5] == {strap_100fd, 1'b1, strap_10fd, strap_10hd};
  endproperty
  a_strap: assert property (p_strap) else $error("adv strap reset");
  property p_pause; pause_mode != 2'b11; endproperty
  a_pause: assert property (p_pause) else $error("both pause modes");
  property p_lp_fix; rd_lp |-> !prdata[15] && !prdata[9] && prdata[12:11] == 2'b00; endproperty
  a_lp_fix: assert property (p_lp_fix) else $error("partner fixed bits");
  property p_ack; $past(code_word_valid, 2) && rd_lp |-> prdata[14]; endproperty
  a_ack: assert property (p_ack) else $error("ack not set");
  property p_lp_word;
    $past(code_word_valid, 2) && !$past(code_word_valid) && rd_lp
      |-> prdata[13:5] == ($past(code_word[13:5], 2) & 9'h12f);
  endproperty
  a_lp_word: assert property (p_lp_word) else $error("partner word");
  property p_exp_fix; rd_exp |-> !prdata[2] && prdata[31:5] == 27'h0; endproperty
  a_exp_fix: assert property (p_exp_fix) else $error("expansion fixed bits");
  property p_page; $past(code_word_valid, 2) && rd_exp |-> prdata[1] && prdata[0]; endproperty
  a_page: assert property (p_page) else $error("page flag");
  property p_pd; $past(parallel_fault, 2) && rd_exp |-> prdata[4]; endproperty
  a_pd: assert property (p_pd) else $error("fault flag");
  property p_done; $past(negotiation_done, 2) && rd_st |-> prdata[5]; endproperty
  a_done: assert property (p_done) else $error("complete bit");
  property p_clear;
    rd_exp && !ev && !$past(ev) ##2 rd_exp |-> !prdata[4] && !prdata[1];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  c_ack: cover property (rd_lp && prdata[14]);
  c_pd: cover property (rd_exp && prdata[4]);
  c_sym: cover property (pause_mode == 2'b01);
endmodule

bind autoneg_ability_registers ability_properties ability_properties_i (.clock(clock),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .strap_100fd(strap_100fd),
  .strap_10fd(strap_10fd), .strap_10hd(strap_10hd), .code_word_valid(code_word_valid),
  .code_word(code_word), .parallel_fault(parallel_fault),
  .negotiation_done(negotiation_done), .pause_mode(pause_mode));

// ==== verif/link_partner.sv ====
// remote link partner: code words, fault and completion pulses
`timescale 1ns/1ps
module link_partner (
  input wire logic clock,
  output logic code_word_valid,
  output logic [15:0] code_word,
  output logic parallel_fault,
  output logic negotiation_done
);
  initial begin
    {code_word_valid, code_word, parallel_fault, negotiation_done} = '0;
  end
  // gap lets a scenario answer promptly or slowly
  task automatic send(input logic [15:0] w, input int gap);
    repeat (gap) @(posedge clock);
    code_word_valid <= 1'b1;
    code_word <= w;
    @(posedge clock);
    code_word_valid <= 1'b0;
    // stale word is inverted so nobody can lean on it
    code_word <= ~w;
  endtask
  task automatic pulse(input logic fault);
    parallel_fault <= fault;
    negotiation_done <= !fault;
    @(posedge clock);
    parallel_fault <= 1'b0;
    negotiation_done <= 1'b0;
  endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the ability register bank
`timescale 1ns/1ps
module testbench;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, e;
  logic speed_100, full_duplex, irq, cwv, pf, nd;
  logic [1:0] pause_mode;
  logic [2:0] st;
  logic [11:0] paddr;
  logic [15:0] cw, w16, adv_m;
  logic [15:0] lp_q[$];
  logic [31:0] pwdata, prdata, r;
  int n_errors = 0;
  int tests_run = 0;
  autoneg_ability_registers autoneg_ability_registers_i (.clock(clock), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_100fd(st[2]),
    .strap_10fd(st[1]), .strap_10hd(st[0]), .code_word_valid(cwv), .code_word(cw),
    .parallel_fault(pf), .negotiation_done(nd), .speed_100(speed_100),
    .full_duplex(full_duplex), .pause_mode(pause_mode), .irq(irq));
  link_partner link_partner_i (.clock(clock), .code_word_valid(cwv), .code_word(cw),
    .parallel_fault(pf), .negotiation_done(nd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // leaves the bus selected so the next call can follow back to back
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
    r = prdata;
    e = pslverr;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [15:0] x);
    bus(1'b0, a, 16'h0000);
    chk(r, {16'h0000, x});
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    st <= 3'($urandom);
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    adv_m = {7'h00, st[2], 1'b1, st[1:0], 5'h01};
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    void'($urandom(32'h3ea0));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    do_reset();
    rdc(12'h010, adv_m);
    rdc(12'h014, 16'h0000);
    rdc(12'h018, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      w16 = 16'($urandom) | (k == 0 ? 16'h0c00 : 16'h0000);
      bus(1'b1, 12'h010, w16);
      adv_m = w16 & 16'h2dff;
      rdc(12'h010, adv_m);
    end
    bus(1'b1, 12'h011, 16'hffff);
    chk({31'h0, e}, 32'h1);
    rdc(12'h3fc, 16'h0000);
    chk({31'h0, e}, 32'h1);
    rdc(12'h010, adv_m);
    bus(1'b1, 12'h014, 16'hffff);
    rdc(12'h014, 16'h0000);
    idle();
    for (int k = 0; k < 4; k++) begin
      w16 = 16'($urandom);
      link_partner_i.send(w16, k);
      lp_q.push_back((w16 & 16'h25ff) | 16'h4000);
      if (k % 2 == 1) rdc(12'h014, lp_q.pop_front());
      rdc(12'h018, {12'h000, w16[15], 3'b011});
      rdc(12'h018, {12'h000, w16[15], 3'b001});
      if (k % 2 == 0) rdc(12'h014, lp_q.pop_front());
      idle();
    end
    link_partner_i.pulse(1'b1);
    rdc(12'h018, {11'h000, 1'b1, w16[15], 3'b001});
    rdc(12'h018, {12'h000, w16[15], 3'b001});
    bus(1'b1, 12'h010, 16'h0d61);
    idle();
    link_partner_i.send(16'h0441, 0);
    link_partner_i.pulse(1'b0);
    bus(1'b0, 12'h004, 16'h0000);
    chk({31'h0, r[5]}, 32'h1);
    idle();
    chk({28'h0, speed_100, full_duplex, pause_mode}, 32'h5);
    bus(1'b1, 12'h000, 16'h3100);
    idle();
    idle();
    chk({28'h0, speed_100, full_duplex, pause_mode}, 32'h5);
    bus(1'b1, 12'h000, 16'h2000);
    idle();
    idle();
    chk({30'h0, speed_100, full_duplex}, 32'h2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 12'h044, 16'h0002);
    idle();
    chk({31'h0, irq}, 32'h1);
    rdc(12'h040, 16'h0007);
    bus(1'b1, 12'h040, 16'h0002);
    idle();
    chk({31'h0, irq}, 32'h0);
    rdc(12'h040, 16'h0005);
    // restart drops acknowledge and completion, keeps the captured fields
    bus(1'b1, 12'h000, 16'h1200);
    rdc(12'h014, 16'h0441);
    rdc(12'h004, 16'h0008);
    idle();
    do_reset();
    rdc(12'h010, adv_m);
    rdc(12'h018, 16'h0000);
    idle();
    chk({31'h0, irq}, 32'h0);
    wrap_up();
  end
endmodule
